// ==== design/assp_port.sv ====
`timescale 1ns/10ps
`default_nettype none
// Operation
// - device is only a slave; never starts a transfer
// - chip select held high means i2c mode, else spi frame enable
// - format bit picks four-wire when clear, shared three-wire line when set
// - spi mode 3: clock idles high, shift on fall, sample on rise
// - transmitter changes on falling edge, receiver samples on rising edge
// - multi-byte flag follows read/write bit in first byte
// - with flag set, pointer advances every eight clocks after first data
// - stepping continues until clocks stop and chip select rises
// - data output released when chip select rises
module assp_port
    import assp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    input wire logic sdio_in,
    output logic sdo_out,
    output logic sdo_oe,
    output logic sdio_out,
    output logic sdio_oe,
    input wire logic three_wire,
    output logic i2c_mode,
    output assp_reg_req_t reg_req,
    input wire logic [7:0] reg_rd_data
);
    logic [2:0] cs_sync_reg;
    logic [2:0] sclk_sync_reg;
    logic [2:0] sdi_sync_reg;
    logic [2:0] sdio_sync_reg;
    logic cs_q_reg;
    logic sclk_q_reg;
    assp_state_t state_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    assp_cmd_t cmd_reg;
    logic first_data_reg;
    logic sdo_reg;
    logic sdo_oe_reg;
    logic sdio_oe_reg;
    logic i2c_reg;
    logic rd_load_reg;
    assp_reg_req_t req_reg;

    // a chip select or clock change counts only once the second and third stages agree
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_sync_reg <= 3'h7;
            sclk_sync_reg <= 3'h7;
            sdi_sync_reg <= 3'h0;
            sdio_sync_reg <= 3'h0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[1:0], cs_n_pin};
            sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
            sdi_sync_reg <= {sdi_sync_reg[1:0], sdi_pin};
            sdio_sync_reg <= {sdio_sync_reg[1:0], sdio_in};
        end
    end

    wire cs_agree = cs_sync_reg[1] == cs_sync_reg[2];
    wire sclk_agree = sclk_sync_reg[1] == sclk_sync_reg[2];
    wire cs_next = cs_agree ? cs_sync_reg[2] : cs_q_reg;
    wire sclk_next = sclk_agree ? sclk_sync_reg[2] : sclk_q_reg;
    wire sclk_rise = sclk_next && !sclk_q_reg;
    wire sclk_fall = !sclk_next && sclk_q_reg;
    wire cs_active = !cs_next;
    wire cs_release = cs_next && !cs_q_reg;
    wire rx_bit = three_wire ? sdio_sync_reg[2] : sdi_sync_reg[2];
    wire [7:0] rx_byte = {shift_reg[6:0], rx_bit};
    wire byte_done = sclk_rise && (bit_reg == ASSP_BIT_LAST);
    wire in_read = (state_reg == ASSP_DATA) && cmd_reg.rw;
    // step only after the first data byte, and only with the flag set
    wire [5:0] addr_step = (cmd_reg.multi_byte_flag && !first_data_reg) ?
                           cmd_reg.addr + 6'h01 : cmd_reg.addr;
    // read data for the next byte is fetched once the previous ends; after a data byte only with the flag set
    wire fetch = byte_done && ((state_reg == ASSP_CMD && rx_byte[ASSP_RW_POS])
                 || (in_read && cmd_reg.multi_byte_flag));
    // the next fetch follows the address that this byte was given
    wire [5:0] fetch_addr = (state_reg == ASSP_CMD) ? rx_byte[5:0]
                            : addr_step + 6'h01;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_q_reg <= 1'b1;
            sclk_q_reg <= 1'b1;
        end else begin
            cs_q_reg <= cs_next;
            sclk_q_reg <= sclk_next;
        end
    end

    // slave only: every transition below waits on the master's pins
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ASSP_IDLE;
            bit_reg <= ASSP_BIT_RESET;
            shift_reg <= ASSP_BYTE_RESET;
            cmd_reg <= '0;
            first_data_reg <= 1'b1;
        end else if (!cs_active) begin
            state_reg <= ASSP_IDLE;
            bit_reg <= ASSP_BIT_RESET;
            first_data_reg <= 1'b1;
        end else begin
            if (state_reg == ASSP_IDLE) begin
                state_reg <= ASSP_CMD;
            end
            if (sclk_rise) begin
                bit_reg <= bit_reg + 3'h1;
                shift_reg <= rx_byte;
            end
            if (byte_done && state_reg == ASSP_CMD) begin
                cmd_reg <= rx_byte;
                state_reg <= ASSP_DATA;
                first_data_reg <= 1'b1;
            end else if (byte_done && state_reg == ASSP_DATA) begin
                cmd_reg.addr <= addr_step;
                first_data_reg <= 1'b0;
            end
        end
    end

    // named decodes keep the clocked blocks below short
    wire in_write = (state_reg == ASSP_DATA) && !cmd_reg.rw;
    wire wr_fire = byte_done && in_write && cs_active;
    wire rd_fire = fetch && cs_active;
    wire [5:0] req_addr = fetch ? fetch_addr : addr_step;
    wire sdo_shift = sclk_fall && in_read;
    wire sdo_drive = cs_active && !three_wire && !cs_release;
    wire sdio_drive = cs_active && three_wire && in_read
                      && (sclk_fall || sdio_oe_reg);

    // write strobes each received data byte; read strobe asks for the next byte
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_reg <= '0;
        end else begin
            req_reg.wr_stb <= wr_fire;
            req_reg.rd_stb <= rd_fire;
            req_reg.addr <= req_addr;
            req_reg.data <= rx_byte;
        end
    end

    // register file answers one cycle after the strobe, so load then
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_load_reg <= 1'b0;
        end else begin
            rd_load_reg <= req_reg.rd_stb;
        end
    end

    // the load lands well before the first falling edge of the byte
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_reg <= ASSP_BYTE_RESET;
        end else if (rd_load_reg) begin
            tx_reg <= reg_rd_data;
        end else if (sdo_shift) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    // output line: msb of tx byte on each falling edge of a read data byte
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sdo_reg <= 1'b0;
        end else if (sdo_shift) begin
            sdo_reg <= tx_reg[7];
        end
    end

    // released once synced chip select goes high
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sdo_oe_reg <= 1'b0;
        end else begin
            sdo_oe_reg <= sdo_drive;
        end
    end

    // shared line stays undriven through command bytes and writes
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sdio_oe_reg <= 1'b0;
        end else begin
            sdio_oe_reg <= sdio_drive;
        end
    end

    // i2c support itself lives elsewhere; only the selection here
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            i2c_reg <= 1'b0;
        end else begin
            i2c_reg <= cs_next;
        end
    end

    assign sdo_out = sdo_reg;
    assign sdo_oe = sdo_oe_reg;
    assign sdio_out = sdo_reg;
    assign sdio_oe = sdio_oe_reg;
    assign i2c_mode = i2c_reg;
    assign reg_req = req_reg;
endmodule : assp_port
`default_nettype wire

// ==== design/assp_pkg.sv ====
package assp_pkg;
    localparam int ASSP_SYNC_STAGES = 3;
    localparam logic [5:0] ASSP_ADDR_RESET = 6'h00;
    localparam logic [7:0] ASSP_BYTE_RESET = 8'h00;
    localparam logic [2:0] ASSP_BIT_LAST = 3'h7;
    localparam logic [2:0] ASSP_BIT_RESET = 3'h0;
    localparam int ASSP_RW_POS = 7;
    localparam int ASSP_MB_POS = 6;
    localparam int ASSP_LINK_PERIOD_NS = 200;
    localparam int ASSP_CLK_PERIOD_NS = 50;

    typedef enum logic [2:0] {
        ASSP_IDLE = 3'b001,
        ASSP_CMD = 3'b010,
        ASSP_DATA = 3'b100
    } assp_state_t;

    typedef struct packed {
        logic rw;
        logic multi_byte_flag;
        logic [5:0] addr;
    } assp_cmd_t;

    typedef struct packed {
        logic wr_stb;
        logic rd_stb;
        logic [5:0] addr;
        logic [7:0] data;
    } assp_reg_req_t;
endpackage : assp_pkg

// ==== dv/assp_port_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module assp_port_chk
    import assp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic sdi_pin,
    input wire logic sdio_in,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic three_wire,
    input wire logic i2c_mode,
    input wire assp_reg_req_t reg_req,
    input wire logic [7:0] reg_rd_data
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_oe_release: assert property ($rose(cs_n_pin) |-> ##6
        !sdo_oe && !sdio_oe) else $error("output enable held");
    a_idle_quiet: assert property (cs_n_pin [*6] |->
        !reg_req.wr_stb && !reg_req.rd_stb) else $error("idle strobe");
    a_wr_pulse: assert property (reg_req.wr_stb |=>
        !reg_req.wr_stb [*8]) else $error("write strobes too close");
    a_rd_pulse: assert property (reg_req.rd_stb |=>
        !reg_req.rd_stb [*8]) else $error("read strobes too close");
    a_sdio_mode: assert property (sdio_oe |->
        three_wire && !sdo_oe) else $error("shared line misdriven");
    a_sdo_mode: assert property (sdo_oe |-> !three_wire)
        else $error("output pin driven in shared mode");
    a_i2c_select: assert property (cs_n_pin [*7] |-> i2c_mode)
        else $error("i2c mode missing");
    a_spi_select: assert property (!cs_n_pin [*7] |-> !i2c_mode)
        else $error("i2c mode in frame");
    a_sdo_hold: assert property ($changed(sdo_out) |->
        !$past(sclk_pin, 2)) else $error("output moved while clock high");
endmodule : assp_port_chk
bind assp_port assp_port_chk assp_port_chk_i (.*);
`default_nettype wire

// ==== dv/assp_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module assp_host (
    input wire logic clk,
    output logic cs_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso
);
    initial {cs_n, sclk, mosi} = 3'h6;
    task automatic start();
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : start
    task automatic xfer(input logic [7:0] b, input int nb,
        output logic [7:0] r);
        for (int i = 7; i > 7 - nb; i--) begin
            sclk <= 1'b0;
            mosi <= b[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            r[i] = miso; // late sample: the port answers ~4 cycles late
        end
    endtask : xfer
    task automatic stop();
        cs_n <= 1'b1;
        sclk <= 1'b1;
        mosi <= ~mosi; // a released line shows no stale bit
        repeat (8) @(posedge clk);
    endtask : stop
endmodule : assp_host
`default_nettype wire

// ==== dv/test_assp_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_assp_port;
    import assp_pkg::*;
    logic ref_clk = 0, reset_n = 0, three_wire = 0;
    logic mosi, cs_n, sclk, sdo_out, sdo_oe, sdio_out, sdio_oe, i2c_mode;
    logic [7:0] reg_rd_data = 8'h00, r;
    logic [31:0] seed = 32'h4E25415B;
    assp_reg_req_t reg_req, e;
    assp_reg_req_t exp_q[$];
    int n_errors = 0, comparisons = 0;
    wire logic line = sdio_oe ? sdio_out : mosi;
    wire logic miso = three_wire ? line : (sdo_oe ? sdo_out : ~sdo_out);
    always #25 ref_clk = ~ref_clk;
    assp_host assp_host_i (.clk(ref_clk), .cs_n(cs_n), .sclk(sclk),
        .mosi(mosi), .miso(miso));
    assp_port assp_port_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .cs_n_pin(cs_n), .sclk_pin(sclk), .sdi_pin(mosi), .sdio_in(line),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .three_wire(three_wire), .i2c_mode(i2c_mode),
        .reg_req(reg_req), .reg_rd_data(reg_rd_data));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [7:0] rdv(logic [5:0] a);
        return {a, 2'h2} ^ 8'h5A;
    endfunction : rdv
    task automatic chk(string n, logic [15:0] x, logic [15:0] s);
        comparisons++;
        if (s !== x) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", n, x, s);
        end
    endtask : chk
    task automatic end_of_test();
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    always @(posedge ref_clk) begin
        if (reg_req.rd_stb)
            reg_rd_data <= rdv(reg_req.addr);
        if (reg_req.wr_stb || reg_req.rd_stb) begin
            e = exp_q.pop_front();
            if (e.rd_stb)
                e.data = reg_req.data;
            chk("req", e, reg_req);
        end
    end
    task automatic frame(logic rd, logic mb, int n);
        logic [5:0] a;
        logic [7:0] d;
        a = rnd();
        if (rd)
            exp_q.push_back('{1'b0, 1'b1, a, 8'h00});
        assp_host_i.start();
        assp_host_i.xfer({rd, mb, a}, 8, r);
        for (int k = 0; k < n; k++) begin
            d = rnd();
            if (!rd)
                exp_q.push_back('{1'b1, 1'b0, a + (mb ? k : 0), d});
            else if (mb)
                exp_q.push_back('{1'b0, 1'b1, a + k + 1, 8'h00});
            assp_host_i.xfer(rd ? 8'h00 : d, 8, r);
            if (rd)
                chk("rd", rdv(a + k), r);
        end
        assp_host_i.stop();
    endtask : frame
    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        for (int m = 0; m < 2; m++) begin
            three_wire <= m[0];
            frame(0, 1, 3);
            frame(0, 0, 2);
            frame(1, 1, 3);
            frame(1, 0, 1);
            assp_host_i.start(); // aborted partial byte, no strobe
            assp_host_i.xfer(8'h5A, 4, r);
            assp_host_i.stop();
        end
        chk("left", 0, exp_q.size());
        end_of_test();
    end
    initial begin
        #1000000;
        n_errors++;
        end_of_test();
    end
endmodule : test_assp_port
`default_nettype wire
